/* File: common/fwkl_pkg.sv */
// constants and types shared by the flash write key lock
package fwkl_pkg;

    // ----------------------------------------------------------------
    // register placement and layout
    // ----------------------------------------------------------------
    localparam logic [7:0] FWKL_KEY_ADDR = 8'hB7;
    localparam logic [7:0] FWKL_KEY_RESET = 8'h00;
    localparam int FWKL_REG_W = 8;
    localparam int FWKL_STATE_W = 2;
    localparam logic [5:0] FWKL_UNUSED_RD = 6'h00;

    // ----------------------------------------------------------------
    // key sequence values
    // ----------------------------------------------------------------
    localparam logic [7:0] FWKL_KEY_FIRST = 8'hA5;
    localparam logic [7:0] FWKL_KEY_SECOND = 8'hF1;

    // ----------------------------------------------------------------
    // lock state codes as seen on a read
    // ----------------------------------------------------------------
    localparam logic [1:0] FWKL_CODE_LOCKED = 2'h0;
    localparam logic [1:0] FWKL_CODE_FIRST = 2'h1;
    localparam logic [1:0] FWKL_CODE_OPEN = 2'h2;
    localparam logic [1:0] FWKL_CODE_LOCKOUT = 2'h3;

    // lock sequencer states
    typedef enum logic [1:0] {
        FWKL_ST_LOCKED,
        FWKL_ST_FIRST,
        FWKL_ST_OPEN,
        FWKL_ST_LOCKOUT
    } fwkl_state_t;

endpackage

/* File: sim/fwkl_flash_model.sv */
// flash controller model answering write and erase commands with done
`timescale 1ns/1ns
module fwkl_flash_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // commands and answer delay
    input wire logic flash_write_in,
    input wire logic flash_erase_in,
    input wire logic [3:0] latency_in,
    // completion
    output logic flash_done_out
);
    logic [4:0] cnt_r;
    // count down from a command, pulse done once when it ends
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 5'h00;
            flash_done_out <= 1'b0;
        end else begin
            flash_done_out <= (cnt_r == 5'h01);
            if (flash_write_in || flash_erase_in) begin
                cnt_r <= {1'b0, latency_in} + 5'h01;
            end else if (cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
            end
        end
    end
endmodule

/* File: sim/tb_flash_write_key_lock.sv */
// self-checking bench for the flash write key lock
`timescale 1ns/1ns
module tb_flash_write_key_lock;
    import fwkl_pkg::*;
    logic clk = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, dwr = 1'b0;
    logic swe = 1'b0, see = 1'b0, done, fw, fe, ramw;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, fdata, dd = 8'h00;
    logic [7:0] lf = 8'h13;
    logic [15:0] da = 16'h0000, faddr;
    logic [1:0] st, ecode;
    logic [3:0] lat = 4'h0;
    logic ce = 1'b1;
    int err_total = 0, checks_done = 0, i;
    // clock source, 10 ns period
    always #5 clk = ~clk;
    fwkl_lock dut (.core_clk_in(clk), .rst_in(rst_in), .ce_in(ce),
        .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
        .sfr_wdata_in(wd), .sfr_rdata_out(rdata),
        .store_write_enable_in(swe), .store_erase_enable_in(see),
        .dsm_wr_in(dwr), .dsm_addr_in(da), .dsm_data_in(dd),
        .flash_done_in(done), .flash_write_out(fw), .flash_erase_out(fe),
        .flash_addr_out(faddr), .flash_data_out(fdata),
        .ram_write_out(ramw), .lock_state_out(st));
    fwkl_flash_model fm (.core_clk_in(clk), .rst_in(rst_in),
        .flash_write_in(fw), .flash_erase_in(fe), .latency_in(lat),
        .flash_done_out(done));
    // ----------------------------------------------------------------
    // expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] rnd(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // lock code after a key write
    function automatic logic [1:0] exp_key(logic [1:0] c, logic [7:0] d);
        if (c == FWKL_CODE_LOCKOUT) return c;
        if (c == FWKL_CODE_LOCKED && d == FWKL_KEY_FIRST) return 2'h1;
        if (c == FWKL_CODE_FIRST && d == FWKL_KEY_SECOND) return 2'h2;
        return FWKL_CODE_LOCKOUT;
    endfunction
    // ----------------------------------------------------------------
    // driver and check tasks
    // ----------------------------------------------------------------
    task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_in = 1'b1;
        @(negedge clk);
        rst_in = 1'b0;
        ecode = FWKL_CODE_LOCKED;
    endtask
    task automatic key_wr(logic [7:0] a, logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        if (a == FWKL_KEY_ADDR) ecode = exp_key(ecode, d);
        chk("lock state", {14'h0, st}, {14'h0, ecode});
        // idle cycle so the strobe is never raised where it was just lowered
        @(negedge clk);
    endtask
    task automatic key_rd();
        addr = FWKL_KEY_ADDR;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("read data", {8'h0, rdata}, {14'h0, ecode});
        @(negedge clk);
    endtask
    task automatic flash_op(logic we, logic ee);
        lf = rnd(lf);
        dd = lf;
        da = {lf, ~lf};
        lat = lf[3:0];
        swe = we;
        see = ee;
        dwr = 1'b1;
        @(negedge clk);
        dwr = 1'b0;
        chk("ram write", {15'h0, ramw}, {15'h0, !we});
        chk("addr", faddr, {lf, ~lf});
        chk("data", {8'h0, fdata}, {8'h0, lf});
        if (we && ecode != FWKL_CODE_OPEN) ecode = FWKL_CODE_LOCKOUT;
        chk("write", {15'h0, fw}, {15'h0, we && !ee && ecode == 2'h2});
        chk("erase", {15'h0, fe}, {15'h0, we && ee && ecode == 2'h2});
        chk("state", {14'h0, st}, {14'h0, ecode});
        if (we && ecode == FWKL_CODE_OPEN) begin
            for (i = 0; i < 40 && st === FWKL_CODE_OPEN; i++) @(negedge clk);
            if (i == 40) begin
                err_total++;
                end_of_test();
            end
            ecode = FWKL_CODE_LOCKED;
            chk("relock", {14'h0, st}, {14'h0, ecode});
        end
        swe = 1'b0;
        see = 1'b0;
        @(negedge clk);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        ecode = FWKL_CODE_LOCKED;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_in = 1'b0;
        key_rd();
        // armed write then armed erase, each relocks after done
        for (int k = 0; k < 2; k++) begin
            key_wr(FWKL_KEY_ADDR, FWKL_KEY_FIRST);
            key_wr(FWKL_KEY_ADDR, FWKL_KEY_SECOND);
            key_rd();
            flash_op(1'b1, k[0]);
        end
        flash_op(1'b0, 1'b0);
        flash_op(1'b1, 1'b0);
        key_wr(FWKL_KEY_ADDR, FWKL_KEY_FIRST);
        key_wr(FWKL_KEY_ADDR, FWKL_KEY_SECOND);
        key_rd();
        do_reset();
        key_rd();
        // clock enable low: a wrong key write is not taken
        ce = 1'b0;
        addr = FWKL_KEY_ADDR;
        wd = 8'h00;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        ce = 1'b1;
        chk("frozen state", {14'h0, st}, {14'h0, ecode});
        @(negedge clk);
        // random keys, stray addresses and random first bytes
        for (int k = 0; k < 12; k++) begin
            lf = rnd(lf);
            key_wr((lf[7:0] == 8'hB7) ? 8'hB6 : lf, FWKL_KEY_FIRST);
            lf = rnd(lf);
            key_wr(FWKL_KEY_ADDR, lf[0] ? FWKL_KEY_FIRST : lf);
            lf = rnd(lf);
            key_wr(FWKL_KEY_ADDR, lf[1] ? FWKL_KEY_SECOND : lf);
            key_rd();
            do_reset();
        end
        // a key write while open locks out
        key_wr(FWKL_KEY_ADDR, FWKL_KEY_FIRST);
        key_wr(FWKL_KEY_ADDR, FWKL_KEY_SECOND);
        key_wr(FWKL_KEY_ADDR, FWKL_KEY_SECOND);
        key_rd();
        end_of_test();
    end
endmodule

/* File: src/fwkl_lock.sv */
// flash write key lock: key register, arming and lockout of flash writes
//
// Notes on behaviour
// R01 - writing A5 then F1 to the key register arms one flash write or erase
// R02 - permission drops by itself once the armed write or erase has finished
// R03 - any key write off the expected sequence locks flash out
// R04 - a flash write or erase attempted while unarmed is blocked and locks out
// R05 - lockout ignores key writes and lasts until device reset
// R06 - software may force lockout by writing a non-A5 first key
// R07 - a read returns lock state in bits 1-0: locked, first, open, lockout
// R08 - key register is eight bits, resets to zero, same address on all pages
// R09 - data-space writes reach flash only while store write enable is set
// R10 - with erase and write enable set, a flash write erases the page
// R11 - a read returns zero in bits 7-2, never the key value
`timescale 1ns/1ns
module fwkl_lock
    import fwkl_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock, reset and enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // special function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // program store control bits
    input wire logic store_write_enable_in,
    input wire logic store_erase_enable_in,
    // data-space move write from the core
    input wire logic dsm_wr_in,
    input wire logic [ADDR_W-1:0] dsm_addr_in,
    input wire logic [7:0] dsm_data_in,
    // flash controller handshake
    input wire logic flash_done_in,
    output logic flash_write_out,
    output logic flash_erase_out,
    output logic [ADDR_W-1:0] flash_addr_out,
    output logic [7:0] flash_data_out,
    // data ram write path
    output logic ram_write_out,
    // lock state for status
    output logic [1:0] lock_state_out
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
        $error("fwkl_lock: ADDR_W must be 1 to 32");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        fwkl_state_t st;
        logic busy;
        logic [1:0] code;
        logic [7:0] rdata;
        logic wr;
        logic er;
        logic ram;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fwkl_regs_t;

    fwkl_regs_t s_r;
    fwkl_regs_t s_nxt;
    logic key_wr;
    logic key_rd;
    logic flash_try;

    // decode of key register accesses and flash-targeted writes
    assign key_wr = sfr_wr_in && (sfr_addr_in == FWKL_KEY_ADDR); // [R08]
    assign key_rd = sfr_rd_in && (sfr_addr_in == FWKL_KEY_ADDR);
    assign flash_try = dsm_wr_in && store_write_enable_in; // [R09]

    // code of a sequencer state
    function automatic logic [1:0] fwkl_code(input fwkl_state_t st);
        logic [1:0] c;
        c = FWKL_CODE_LOCKED;
        unique case (st)
            FWKL_ST_LOCKED: c = FWKL_CODE_LOCKED;
            FWKL_ST_FIRST: c = FWKL_CODE_FIRST;
            FWKL_ST_OPEN: c = FWKL_CODE_OPEN;
            FWKL_ST_LOCKOUT: c = FWKL_CODE_LOCKOUT;
        endcase
        return c; // [R07]
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.wr = 1'b0;
        s_nxt.er = 1'b0;
        s_nxt.ram = 1'b0;
        // armed operation finished: drop permission
        if (s_r.busy && flash_done_in) begin
            s_nxt.busy = 1'b0;
            if (s_r.st == FWKL_ST_OPEN) begin
                s_nxt.st = FWKL_ST_LOCKED; // [R02]
            end
        end
        // key sequence
        if (key_wr) begin
            unique case (s_r.st)
                FWKL_ST_LOCKED: begin
                    if (sfr_wdata_in == FWKL_KEY_FIRST) begin
                        s_nxt.st = FWKL_ST_FIRST; // [R01]
                    end else begin
                        s_nxt.st = FWKL_ST_LOCKOUT; // [R03] [R06]
                    end
                end
                FWKL_ST_FIRST: begin
                    if (sfr_wdata_in == FWKL_KEY_SECOND) begin
                        s_nxt.st = FWKL_ST_OPEN; // [R01]
                    end else begin
                        s_nxt.st = FWKL_ST_LOCKOUT; // [R03]
                    end
                end
                FWKL_ST_OPEN: s_nxt.st = FWKL_ST_LOCKOUT; // [R03]
                FWKL_ST_LOCKOUT: s_nxt.st = FWKL_ST_LOCKOUT; // [R05]
            endcase
        end
        // data-space write: flash if enabled and armed, lockout if enabled but not armed, else data ram
        if (dsm_wr_in) begin
            s_nxt.addr = dsm_addr_in;
            s_nxt.data = dsm_data_in;
            if (!store_write_enable_in) begin
                s_nxt.ram = 1'b1; // [R09]
            end else if (s_r.st == FWKL_ST_OPEN && !s_r.busy && !key_wr) begin
                s_nxt.busy = 1'b1;
                s_nxt.er = store_erase_enable_in; // [R10]
                s_nxt.wr = !store_erase_enable_in; // [R09]
            end else begin
                s_nxt.st = FWKL_ST_LOCKOUT; // [R04]
            end
        end
        s_nxt.code = fwkl_code(s_nxt.st);
        // read returns state only, upper bits zero
        if (key_rd) begin
            s_nxt.rdata = {FWKL_UNUSED_RD, s_r.code}; // [R07] [R11]
        end
    end

    // register the state, frozen while the enable is low
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0; // [R05] [R08]
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign sfr_rdata_out = s_r.rdata;
    assign flash_write_out = s_r.wr;
    assign flash_erase_out = s_r.er;
    assign flash_addr_out = s_r.addr;
    assign flash_data_out = s_r.data;
    assign ram_write_out = s_r.ram;
    assign lock_state_out = s_r.code;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_first_key;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && key_wr && !dsm_wr_in && lock_state_out == FWKL_CODE_LOCKED
            && sfr_wdata_in == FWKL_KEY_FIRST
            |=> lock_state_out == FWKL_CODE_FIRST;
    endproperty
    a_first_key: assert property (p_first_key) // [R01]
        else $error("first key did not advance the lock");

    property p_second_key;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && key_wr && !dsm_wr_in && lock_state_out == FWKL_CODE_FIRST
            && sfr_wdata_in == FWKL_KEY_SECOND
            |=> lock_state_out == FWKL_CODE_OPEN;
    endproperty
    a_second_key: assert property (p_second_key) // [R01]
        else $error("second key did not unlock");

    property p_bad_key;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && key_wr && (lock_state_out == FWKL_CODE_OPEN
            || (lock_state_out == FWKL_CODE_LOCKED
                && sfr_wdata_in != FWKL_KEY_FIRST)
            || (lock_state_out == FWKL_CODE_FIRST
                && sfr_wdata_in != FWKL_KEY_SECOND))
            |=> lock_state_out == FWKL_CODE_LOCKOUT;
    endproperty
    a_bad_key: assert property (p_bad_key) // [R03]
        else $error("wrong key did not lock out");

    property p_unarmed;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && flash_try && (lock_state_out != FWKL_CODE_OPEN || s_r.busy)
            |=> lock_state_out == FWKL_CODE_LOCKOUT
                && !flash_write_out && !flash_erase_out;
    endproperty
    a_unarmed: assert property (p_unarmed) // [R04]
        else $error("unarmed flash write was not blocked");

    property p_lockout_holds;
        @(posedge core_clk_in) disable iff (rst_in)
        lock_state_out == FWKL_CODE_LOCKOUT
            |=> lock_state_out == FWKL_CODE_LOCKOUT;
    endproperty
    a_lockout_holds: assert property (p_lockout_holds) // [R05]
        else $error("lockout left without reset");

    property p_relock;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && s_r.busy && flash_done_in && !key_wr && !dsm_wr_in
            && lock_state_out == FWKL_CODE_OPEN
            |=> lock_state_out == FWKL_CODE_LOCKED;
    endproperty
    a_relock: assert property (p_relock) // [R02]
        else $error("lock did not re-arm after the operation");

    property p_ram_route;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && dsm_wr_in && !store_write_enable_in
            |=> ram_write_out && !flash_write_out && !flash_erase_out;
    endproperty
    a_ram_route: assert property (p_ram_route) // [R09]
        else $error("disabled store write reached flash");

    property p_erase;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && flash_try && store_erase_enable_in && !key_wr && !s_r.busy
            && lock_state_out == FWKL_CODE_OPEN
            |=> flash_erase_out && !flash_write_out
                && flash_addr_out == $past(dsm_addr_in);
    endproperty
    a_erase: assert property (p_erase) // [R10]
        else $error("armed erase not issued");

    property p_read;
        @(posedge core_clk_in) disable iff (rst_in)
        ce_in && key_rd |=> sfr_rdata_out[7:2] == FWKL_UNUSED_RD
            && sfr_rdata_out[1:0] == $past(lock_state_out);
    endproperty
    a_read: assert property (p_read) // [R07] [R11]
        else $error("key register read returned wrong value");

endmodule
